// ---- hw/cap_edge_detect.sv ----
`timescale 1ns/10ps
module cap_edge_detect (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic pin,
	input wire tcc_pkg::edge_sel_e edge_sel,
	output logic capture
);
	import tcc_pkg::*;

	capsync_s st_r;
	capsync_s st_nxt;
	logic rise;
	logic fall;

	// Edges come from the settled stages only; s1 may be metastable
	assign rise = st_r.s2 & ~st_r.s3;
	assign fall = ~st_r.s2 & st_r.s3;

	// Next state: shift the pin in, pick the qualifying edge
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		unique case (edge_sel)
			EDGE_OFF: st_nxt.hit = 1'b0;
			EDGE_RISE: st_nxt.hit = rise;
			EDGE_FALL: st_nxt.hit = fall;
			EDGE_BOTH: st_nxt.hit = rise | fall;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// One pulse per edge, straight from a flop
	assign capture = st_r.hit;

endmodule : cap_edge_detect

// ---- hw/tcc_cfg.svh ----
// Behaviour
// - Control register bits 7 and 6 always read 1; writes to them ignored.
// - Clear select 00 never clears, 01 on general one event, 10 on dedicated two.
// - Clear select 11 clears the counter together with the paired timer.
// - General one clear is compare match, or capture when in capture mode.
// - Second edge field: 00 none, 01 rising, 10 falling, 11 both edges.
// - Reset zeroes second edge field (compare); nonzero makes it capture.
// - First edge field: 00 none, 01 rising, 10 falling, 11 both edges.
// - Reset zeroes first edge field (compare); nonzero makes it capture.
// - Interrupt raised only when source enable is 1 and its flag is set.
// - Enable bit 4 gates overflow interrupt; resets to 0.
// - Enable bit 3 gates dedicated two match interrupt.
// - Enable register bits 7 to 5 always read 1 and are not writable.
// - Enable bit 2 gates dedicated one match interrupt; resets to 0.
// - Enable bits 1 and 0 gate general two and one events; reset 0.
// - Overflow flag sets when counter wraps from FFFF to 0000.
// - Flag cleared by reading it as 1 then writing 0 (ones ignored), or by writing 1 to the clear register.
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// Register word offsets
`define OFF_CTRL_LOW 4'h0
`define OFF_IRQ_ENABLE 4'h1
`define OFF_EVENT_FLAGS 4'h2
`define OFF_FLAG_CLEAR 4'h3

// Reset values
`define RST_CTRL_LOW 8'hC0
`define RST_IRQ_ENABLE 8'hE0
`define RST_EVENT_FLAGS 8'hE0

// Reserved bits reading as one
`define RSV_CTRL_LOW 2'b11
`define RSV_FLAGS_HIGH 3'b111

// Field positions
`define POS_CLR_SEL 4
`define POS_EDGE2 2
`define POS_EDGE1 0
`define POS_OVERFLOW 4
`define POS_DEDICATED2 3
`define POS_DEDICATED1 2
`define POS_GENERAL2 1
`define POS_GENERAL1 0

// Counter limits
`define CNT_MAX 16'hFFFF
`define CNT_MIN 16'h0000

`endif

// ---- hw/tcc_pkg.sv ----
package tcc_pkg;

	// Counter clear source
	typedef enum logic [1:0] {
		CLR_NONE = 2'b00,
		CLR_GR1 = 2'b01,
		CLR_DR2 = 2'b10,
		CLR_SYNC = 2'b11
	} clr_sel_e;

	// Capture edge choice
	typedef enum logic [1:0] {
		EDGE_OFF = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11
	} edge_sel_e;

	typedef struct packed {
		clr_sel_e counter_clear_select;
		edge_sel_e second_capture_edge_select;
		edge_sel_e first_capture_edge_select;
	} ctrl_low_s;

	// One bit per interrupt source, bit 4 down to bit 0
	typedef struct packed {
		logic overflow_flag;
		logic dedicated2_match_flag;
		logic dedicated1_match_flag;
		logic general2_event_flag;
		logic general1_event_flag;
	} ev_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;

	typedef struct packed {
		logic general_reg_one;
		logic general_reg_two;
		logic dedicated_reg_one;
		logic dedicated_reg_two;
	} match_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic hit;
	} capsync_s;

	typedef struct packed {
		ctrl_low_s ctrl;
		ev_s ien;
		ev_s flags;
		ev_s armed;
		logic [7:0] rdata;
		logic [15:0] cnt_prev;
		logic cnt_clear;
	} top_state_s;

endpackage : tcc_pkg

// ---- hw/timer_clear_capture_irq_ctrl.sv ----
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "tcc_cfg.svh"
module timer_clear_capture_irq_ctrl (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire tcc_pkg::bus_req_s bus_req,
	output logic [7:0] bus_rdata,
	input wire logic [15:0] cnt_val,
	input wire tcc_pkg::match_s match_in,
	input wire logic pair_clear,
	input wire logic cap1_pin,
	input wire logic cap2_pin,
	output logic cnt_clear,
	output logic gr1_capture,
	output logic gr2_capture,
	output logic gr1_is_capture,
	output logic gr2_is_capture,
	output tcc_pkg::ev_s irq_req,
	output logic irq
);
	import tcc_pkg::*;

	top_state_s st_r;
	top_state_s st_nxt;

	// Decoded bus accesses
	logic wr_ctrl;
	logic wr_ien;
	logic wr_flags;
	logic wr_clear;
	logic rd_ctrl;
	logic rd_ien;
	logic rd_flags;

	// Events raised this cycle
	ev_s ev_set;
	ev_s ev_clr;
	logic wrap;
	logic gr1_event;
	logic gr2_event;
	logic clear_hit;

	// Read-back images
	logic [7:0] ctrl_img;
	logic [7:0] ien_img;
	logic [7:0] flags_img;

	//------------------------------------------------------------
	// Capture inputs: one synchroniser and edge picker per pin
	//------------------------------------------------------------

	// First general register capture path
	cap_edge_detect u_cap1 (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pin(cap1_pin),
		.edge_sel(st_r.ctrl.first_capture_edge_select),
		.capture(gr1_capture)
	);

	// Second general register capture path
	cap_edge_detect u_cap2 (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pin(cap2_pin),
		.edge_sel(st_r.ctrl.second_capture_edge_select),
		.capture(gr2_capture)
	);

	//------------------------------------------------------------
	// Register mode of each general register
	//------------------------------------------------------------

	// Any nonzero edge field turns compare into capture
	assign gr1_is_capture =
		(st_r.ctrl.first_capture_edge_select != EDGE_OFF);
	assign gr2_is_capture =
		(st_r.ctrl.second_capture_edge_select != EDGE_OFF);

	// Edge choice itself lives in the capture paths above
	// and follows the field value directly

	//------------------------------------------------------------
	// Source events
	//------------------------------------------------------------

	// Wrap seen as max followed by min on the counter bus
	assign wrap = (st_r.cnt_prev == `CNT_MAX) &&
		(cnt_val == `CNT_MIN);

	// Compare or capture, never both, per register mode
	assign gr1_event = gr1_is_capture ? gr1_capture :
		match_in.general_reg_one;
	assign gr2_event = gr2_is_capture ? gr2_capture :
		match_in.general_reg_two;

	// Gather the five flag set conditions
	always_comb begin
		ev_set = '0;
		ev_set.overflow_flag = wrap;
		ev_set.dedicated2_match_flag = match_in.dedicated_reg_two;
		ev_set.dedicated1_match_flag = match_in.dedicated_reg_one;
		ev_set.general2_event_flag = gr2_event;
		ev_set.general1_event_flag = gr1_event;
	end

	//------------------------------------------------------------
	// Counter clear source
	//------------------------------------------------------------

	// Select the clear trigger
	always_comb begin
		unique case (st_r.ctrl.counter_clear_select)
			CLR_NONE: clear_hit = 1'b0;
			CLR_GR1: clear_hit = gr1_event;
			CLR_DR2: clear_hit = match_in.dedicated_reg_two;
			CLR_SYNC: clear_hit = pair_clear;
		endcase
	end

	//------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------

	// Writes
	assign wr_ctrl = bus_req.wr && (bus_req.addr == `OFF_CTRL_LOW);
	assign wr_ien = bus_req.wr && (bus_req.addr == `OFF_IRQ_ENABLE);
	assign wr_flags = bus_req.wr && (bus_req.addr == `OFF_EVENT_FLAGS);
	assign wr_clear = bus_req.wr && (bus_req.addr == `OFF_FLAG_CLEAR);

	// Reads
	assign rd_ctrl = bus_req.rd && (bus_req.addr == `OFF_CTRL_LOW);
	assign rd_ien = bus_req.rd && (bus_req.addr == `OFF_IRQ_ENABLE);
	assign rd_flags = bus_req.rd && (bus_req.addr == `OFF_EVENT_FLAGS);

	//------------------------------------------------------------
	// Read-back images with reserved ones forced
	//------------------------------------------------------------

	// Control low: top two bits tied high
	assign ctrl_img = {`RSV_CTRL_LOW, st_r.ctrl};

	// Enable high: top three bits tied high
	assign ien_img = {`RSV_FLAGS_HIGH, st_r.ien};

	// Flags low: same reserved pattern
	assign flags_img = {`RSV_FLAGS_HIGH, st_r.flags};

	//------------------------------------------------------------
	// Flag clearing
	//------------------------------------------------------------

	// Write of 0 clears only a bit that was seen as 1 by a read;
	// writing 1 does nothing. The clear register is a shortcut that
	// skips the read step for drivers that poll.
	always_comb begin
		ev_clr = '0;
		if (wr_flags) begin
			ev_clr = st_r.armed & ~bus_req.wdata[4:0];
		end
		if (wr_clear) begin
			ev_clr = ev_clr | bus_req.wdata[4:0];
		end
	end

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------

	always_comb begin
		st_nxt = st_r;

		// Counter history for wrap detection
		st_nxt.cnt_prev = cnt_val;

		// Clear strobe registered so the counter sees a clean pulse
		st_nxt.cnt_clear = clear_hit;

		// Control low: reserved bits never stored
		if (wr_ctrl) begin
			st_nxt.ctrl = ctrl_low_s'(bus_req.wdata[5:0]);
		end

		// Enable high: only the five enable bits stored
		if (wr_ien) begin
			st_nxt.ien = ev_s'(bus_req.wdata[4:0]);
		end

		// Sticky flags; a set in the clear cycle wins
		st_nxt.flags = (st_r.flags & ~ev_clr) | ev_set;

		// Arm bits seen as 1 by a read; a cleared bit disarms
		st_nxt.armed = st_r.armed & ~ev_clr;
		if (rd_flags) begin
			st_nxt.armed = st_nxt.armed | st_r.flags;
		end

		// Read data for the following cycle; unmapped reads zero
		st_nxt.rdata = 8'h00;
		if (rd_ctrl) begin
			st_nxt.rdata = ctrl_img;
		end
		if (rd_ien) begin
			st_nxt.rdata = ien_img;
		end
		if (rd_flags) begin
			st_nxt.rdata = flags_img;
		end
	end

	//------------------------------------------------------------
	// State register
	//------------------------------------------------------------

	// Reset loads documented initial values; reserved bits are
	// not stored, so only the low fields take the reset values
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r.ctrl <= ctrl_low_s'(6'(`RST_CTRL_LOW));
			st_r.ien <= ev_s'(5'(`RST_IRQ_ENABLE));
			st_r.flags <= ev_s'(5'(`RST_EVENT_FLAGS));
			st_r.armed <= '0;
			st_r.rdata <= 8'h00;
			st_r.cnt_prev <= `CNT_MIN;
			st_r.cnt_clear <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------

	// Register read data stands one cycle after the strobe
	assign bus_rdata = st_r.rdata;

	// Counter clear pulse from a flop, one cycle after the trigger
	assign cnt_clear = st_r.cnt_clear;

	// Per-source requests: flag and its enable both needed
	always_comb begin
		irq_req = st_r.flags & st_r.ien;
		irq_req.overflow_flag =
			st_r.flags.overflow_flag &
			st_r.ien.overflow_flag;
		irq_req.dedicated2_match_flag =
			st_r.flags.dedicated2_match_flag &
			st_r.ien.dedicated2_match_flag;
		irq_req.dedicated1_match_flag =
			st_r.flags.dedicated1_match_flag &
			st_r.ien.dedicated1_match_flag;
		irq_req.general2_event_flag =
			st_r.flags.general2_event_flag &
			st_r.ien.general2_event_flag;
		irq_req.general1_event_flag =
			st_r.flags.general1_event_flag &
			st_r.ien.general1_event_flag;
	end

	// Single level line; stays high until flags cleared or masked
	assign irq = |irq_req;

endmodule : timer_clear_capture_irq_ctrl

// ---- verif/cap_pin_model.sv ----
`timescale 1ns/10ps
module cap_pin_model (
	output logic cap1_pin,
	output logic cap2_pin
);
	initial begin
		cap1_pin = 1'b0;
		cap2_pin = 1'b0;
	end
	// Flip off the clock grid; hold ten cycles so the sync can settle
	task automatic flip(input logic sel);
		#3;
		if (sel)
			cap2_pin = !cap2_pin;
		else
			cap1_pin = !cap1_pin;
		#97;
	endtask : flip
endmodule : cap_pin_model

// ---- verif/tcc_chk.sv ----
`timescale 1ns/10ps
module tcc_chk (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire tcc_pkg::bus_req_s bus_req,
	input wire logic [7:0] bus_rdata,
	input wire logic [15:0] cnt_val,
	input wire tcc_pkg::match_s match_in,
	input wire logic pair_clear,
	input wire logic cnt_clear,
	input wire logic gr1_capture,
	input wire logic gr2_capture,
	input wire logic gr1_is_capture,
	input wire logic gr2_is_capture,
	input wire tcc_pkg::ev_s irq_req,
	input wire logic irq
);
	import tcc_pkg::*;
	logic [7:0] ctl_r;
	logic [4:0] ien_r;
	// Shadow of writes, so modes are known from the bus alone
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctl_r <= 8'h00;
			ien_r <= 5'h00;
		end else if (bus_req.wr && bus_req.addr == 4'h0) begin
			ctl_r <= bus_req.wdata;
		end else if (bus_req.wr && bus_req.addr == 4'h1) begin
			ien_r <= bus_req.wdata[4:0];
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	chk_ctrl_rsv_ones: assert property (
		$past(bus_req.rd) && $past(bus_req.addr) == 4'h0
		|-> bus_rdata[7:6] == 2'b11) else $error("ctrl top bits not 1");
	chk_ien_rsv_ones: assert property (
		$past(bus_req.rd) && $past(bus_req.addr) == 4'h1
		|-> bus_rdata[7:5] == 3'b111) else $error("enable top bits not 1");
	chk_clear_none: assert property (
		ctl_r[5:4] == 2'b00 |=> !cnt_clear) else $error("clear with select 0");
	chk_clear_dr2: assert property (
		ctl_r[5:4] == 2'b10 && match_in.dedicated_reg_two |=> cnt_clear)
		else $error("no clear on dedicated two");
	chk_clear_sync: assert property (
		ctl_r[5:4] == 2'b11 && pair_clear |=> cnt_clear)
		else $error("no clear with paired timer");
	chk_clear_gr1: assert property (
		ctl_r[5:4] == 2'b01 && ctl_r[1:0] == 2'b00
		&& match_in.general_reg_one |=> cnt_clear) else $error("no gr1 clear");
	chk_capture_clear: assert property (
		gr1_capture && ctl_r[5:4] == 2'b01 |=> cnt_clear)
		else $error("no clear on capture");
	chk_mode_first: assert property (
		gr1_is_capture == (ctl_r[1:0] != 2'b00)) else $error("gr1 mode");
	chk_mode_second: assert property (
		gr2_is_capture == (ctl_r[3:2] != 2'b00)) else $error("gr2 mode");
	chk_irq_gated: assert property (
		(irq_req & ~ien_r) == 5'h00 && irq == (|irq_req))
		else $error("request not gated");
	chk_overflow_irq: assert property (
		cnt_val == 16'h0000 && $past(cnt_val) == 16'hFFFF && ien_r[4]
		|=> irq_req.overflow_flag) else $error("overflow missed");
	chk_capture_pulse: assert property (
		gr1_capture |=> !gr1_capture) else $error("capture too long");
	chk_capture2_pulse: assert property (
		gr2_capture |=> !gr2_capture) else $error("capture two too long");
endmodule : tcc_chk

// ---- verif/timer_clear_capture_irq_ctrl_tb.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
	num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module timer_clear_capture_irq_ctrl_tb;
	import tcc_pkg::*;
	logic clk_sys;
	logic nrst;
	bus_req_s bus_req = '0;
	logic [15:0] cnt_val = 16'h0000;
	match_s match_in = '0;
	logic pair_clear = 1'b0;
	logic [7:0] bus_rdata;
	logic cap1_pin, cap2_pin, cnt_clear, gr1_capture, gr2_capture;
	logic gr1_is_capture, gr2_is_capture, irq;
	ev_s irq_req;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int n1 = 0;
	int n2 = 0;
	int nclr = 0;
	always #5 clk_sys = !clk_sys;
	timer_clear_capture_irq_ctrl timer_clear_capture_irq_ctrl_i (.clk_sys,
		.nrst, .bus_req, .bus_rdata, .cnt_val, .match_in, .pair_clear,
		.cap1_pin, .cap2_pin, .cnt_clear, .gr1_capture, .gr2_capture,
		.gr1_is_capture, .gr2_is_capture, .irq_req, .irq);
	cap_pin_model cap_pin_model_i (.cap1_pin, .cap2_pin);
	// Pulse counters and hang guard; run needs about 300 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (gr1_capture === 1'b1) n1++;
		if (gr2_capture === 1'b1) n2++;
		if (cnt_clear === 1'b1) nclr++;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		bus_req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
		#1;
	endtask : wr
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1;
		`CHK(bus_rdata, e)
	endtask : rd
	task automatic t_reset();
		rd(4'h0, 8'hC0);
		rd(4'h1, 8'hE0);
		rd(4'h2, 8'hE0);
		rd(4'h3, 8'h00);
		rd(4'h9, 8'h00);
	endtask : t_reset
	task automatic t_rsv();
		wr(4'h0, 8'h3F);
		rd(4'h0, 8'hFF);
		`CHK(gr1_is_capture, 1'b1)
		`CHK(gr2_is_capture, 1'b1)
		wr(4'h9, 8'h00);
		wr(4'h0, 8'h00);
		rd(4'h0, 8'hC0);
		wr(4'h1, 8'h1F);
		rd(4'h1, 8'hFF);
		wr(4'h1, 8'h03);
	endtask : t_rsv
	task automatic t_edges();
		int e;
		for (e = 0; e < 4; e++) begin
			wr(4'h0, 8'(e * 5));
			n1 = 0;
			n2 = 0;
			cap_pin_model_i.flip(1'b0);
			cap_pin_model_i.flip(1'b1);
			cap_pin_model_i.flip(1'b0);
			cap_pin_model_i.flip(1'b1);
			`CHK(n1, (e == 3) ? 2 : int'(e != 0))
			`CHK(n2, (e == 3) ? 2 : int'(e != 0))
		end
		`CHK(irq_req, ev_s'(5'h03))
	endtask : t_edges
	task automatic cl(input logic [7:0] c, input match_s m, input logic p,
		input logic e);
		wr(4'h0, c);
		@(posedge clk_sys);
		match_in <= m;
		pair_clear <= p;
		@(posedge clk_sys);
		match_in <= '0;
		pair_clear <= 1'b0;
		#1;
		`CHK(cnt_clear, e)
	endtask : cl
	task automatic t_clear();
		cl(8'h20, 4'b0001, 1'b0, 1'b1);
		cl(8'h20, 4'b1000, 1'b0, 1'b0);
		cl(8'h00, 4'b1111, 1'b1, 1'b0);
		cl(8'h30, 4'b0000, 1'b1, 1'b1);
		cl(8'h10, 4'b1000, 1'b0, 1'b1);
		cl(8'h11, 4'b1000, 1'b0, 1'b0);
		nclr = 0;
		cap_pin_model_i.flip(1'b0);
		cap_pin_model_i.flip(1'b0);
		`CHK(nclr, 1)
	endtask : t_clear
	task automatic t_irq();
		int i;
		wr(4'h3, 8'h1F);
		wr(4'h1, 8'h00);
		cnt_val <= 16'hFFFF;
		@(posedge clk_sys);
		cnt_val <= 16'h0000;
		@(posedge clk_sys);
		@(posedge clk_sys);
		#1;
		`CHK(irq, 1'b0)
		wr(4'h2, 8'h00);
		rd(4'h2, 8'hF0);
		wr(4'h1, 8'h10);
		`CHK(irq, 1'b1)
		wr(4'h2, 8'hFF);
		rd(4'h2, 8'hF0);
		wr(4'h2, 8'hE0);
		rd(4'h2, 8'hE0);
		`CHK(irq, 1'b0)
		for (i = 0; i < 4; i++) begin
			wr(4'h3, 8'h1F);
			wr(4'h1, 8'(1 << i));
			cl(8'h00, 4'b1111, 1'b0, 1'b0);
			`CHK(irq_req, ev_s'(5'(1 << i)))
			`CHK(irq, 1'b1)
		end
	endtask : t_irq
	initial begin
		clk_sys = 1'b0;
		nrst = 1'b0;
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset();
		t_rsv();
		t_edges();
		t_clear();
		t_irq();
		end_of_test();
	end
endmodule : timer_clear_capture_irq_ctrl_tb
bind timer_clear_capture_irq_ctrl tcc_chk tcc_chk_i (.clk_sys, .nrst,
	.bus_req, .bus_rdata, .cnt_val, .match_in, .pair_clear, .cnt_clear,
	.gr1_capture, .gr2_capture, .gr1_is_capture, .gr2_is_capture,
	.irq_req, .irq);
